// ===== hdl/bmsel_pkg.sv
// Constants for the boot mode select and byte-wide boot memory loader
package bmsel_pkg;
	localparam logic [15:0] BOOT_CTRL_RESET   = 16'h04A1;
	localparam logic [23:0] INT_INDEX_RESET   = 24'h040000;
	localparam logic [23:0] EXT_INDEX_RESET   = 24'h800000;
	localparam logic [23:0] STRIDE_ONE        = 24'h000001;
	localparam logic [23:0] RESET_VECTOR      = 24'h040004;
	localparam logic [23:0] NOBOOT_VECTOR     = 24'h800004;
	localparam logic [15:0] INT_COUNT_RESET   = 16'h0100;
	localparam logic [15:0] EXT_COUNT_RESET   = 16'h0600;
	localparam logic [2:0]  BYTES_PER_WORD    = 3'h6;
	localparam logic [3:0]  PROM_WAIT_STATES  = 4'h6;
	localparam logic [1:0]  WAIT_MODE_BOTH    = 2'h0;
	localparam logic [1:0]  WAIT_MODE_INT     = 2'h1;
	localparam int          DATA_LSB          = 32;
	localparam int          FIFO_DEPTH        = 16;
	localparam int          WORD_W            = 48;
	localparam logic [2:0]  MODE_NONE         = 3'h0;
	localparam logic [2:0]  MODE_PROM         = 3'h1;
	localparam logic [2:0]  MODE_HOST         = 3'h2;
	localparam logic [2:0]  MODE_LINK         = 3'h3;
	localparam logic [2:0]  MODE_NOBOOT       = 3'h4;
	localparam logic [2:0]  MODE_RESERVED     = 3'h5;
endpackage

// ===== hdl/bmsel_loader.sv
// Boot mode decode, boot-space byte loader and its word FIFO
`timescale 1ns/1ns
module bmsel_fifo #(
	parameter int WIDTH = 48,
	parameter int DEPTH = 16
) (
	input  wire logic             mclk,
	input  wire logic             resetn,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] store [DEPTH];
	logic [AW-1:0]    rdPtr;
	logic [AW-1:0]    wrPtr;
	logic [AW:0]      fill;
	logic             doWrite;
	logic             doRead;
	assign doWrite  = inValid && inReady;
	assign doRead   = outValid && outReady;
	assign inReady  = fill != (AW+1)'(DEPTH);
	assign outValid = fill != '0;
	assign outData  = store[rdPtr];
	always_ff @(posedge mclk) begin
		if (doWrite) begin
			store[wrPtr] <= inData;
		end
	end
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rdPtr <= '0;
			wrPtr <= '0;
			fill  <= '0;
		end else begin
			if (doWrite) begin
				wrPtr <= wrPtr + 1'b1;
			end
			if (doRead) begin
				rdPtr <= rdPtr + 1'b1;
			end
			fill <= fill + (AW+1)'(doWrite) - (AW+1)'(doRead);
		end
	end
endmodule

// Contract
// - PROM strap high, link strap low at reset selects byte-wide PROM boot over external port.
// - Link strap high, PROM strap low, boot-select high selects link port boot.
// - Both straps low, boot-select high selects host boot.
// - Straps low, boot-select low is no-boot; other combinations are reserved.
// - Boot-select pin is a three-state output in PROM boot, input otherwise; here its output is enabled only while the boot-space bit is set.
// - PROM boot drives boot-select as chip select, other selects disabled.
// - Boot internal count resets to 256 words.
// - Boot external count resets to 0x600 bytes.
// - Boot control 0x4A1, internal index 0x40000, external 0x800000, stride one.
// - PROM boot release leaves core idle at reset vector.
// - Bytes packed low byte first into 48-bit words until 256 loaded.
// - Packing field ignored; byte packing forced, instruction word DMA enabled.
// - Unbanked wait states reset to six; read strobe lasts seven cycles.
// - Bytes on data lines 39..32; address starts 0x800000, increments per byte.
// - Read strobe asserts per byte like a normal read with wait states.
// - Boot-space bit clears after kernel load, restoring normal selects.
// - With boot-space bit set, byte packing forced; else byte packing forbidden.
// - With boot-space bit set only DMA asserts boot-select, never core.
// - Both counts decrement per transfer; at zero DMA stops, core resumes.
// - Acknowledge held high internally during reset by a keeper.
// - Wait mode resets to internal plus acknowledge; low ack stalls forever.
module bmsel_loader (
	input  wire logic        mclk,
	input  wire logic        resetn,
	input  wire logic        promBootStrap,
	input  wire logic        linkBootStrap,
	input  wire logic        bootSelectIn,
	output logic             bootSelectOut,
	output logic             bootSelectOe,
	output logic             memSelectEnable,
	output logic [31:0]      extAddr,
	input  wire logic [63:0] extDataIn,
	output logic             readStrobe,
	input  wire logic        ackIn,
	output logic             ackOut,
	output logic             ackOe,
	input  wire logic [1:0]  waitModeIn,
	input  wire logic        waitModeWrite,
	input  wire logic        coreExtAccess,
	output logic             memWrite,
	output logic [23:0]      memAddr,
	output logic [47:0]      memData,
	output logic [2:0]       bootMode,
	output logic             coreIdle,
	output logic             coreResume,
	output logic [23:0]      programCounter,
	output logic [15:0]      bootChannelControl,
	output logic [15:0]      bootInternalCount,
	output logic [15:0]      bootExternalCount,
	output logic [23:0]      bootInternalStride,
	output logic [23:0]      bootExternalStride,
	output logic             bootSpaceSelectBit,
	output logic [1:0]       unbankedWaitMode,
	output logic [3:0]       unbankedWaitStates
);
	typedef enum logic [5:0] {
		BMSEL_SAMPLE = 6'h01,
		BMSEL_STROBE = 6'h02,
		BMSEL_PACK   = 6'h04,
		BMSEL_DRAIN  = 6'h08,
		BMSEL_DONE   = 6'h10,
		BMSEL_HALT   = 6'h20
	} bmsel_state_t;

	bmsel_state_t state;
	logic [3:0]  waitCnt;
	logic [2:0]  byteIdx;
	logic [47:0] packReg;
	logic        packValid;
	logic        packReady;
	logic        fifoValid;
	logic [47:0] fifoData;
	logic [23:0] internalIndex;
	logic        ackOk;

	function automatic logic [2:0] decode_mode(input logic e, input logic l, input logic b);
		if (e && !l) begin
			decode_mode = bmsel_pkg::MODE_PROM;
		end else if (e) begin
			decode_mode = bmsel_pkg::MODE_RESERVED;
		end else if (l) begin
			decode_mode = b ? bmsel_pkg::MODE_LINK : bmsel_pkg::MODE_RESERVED;
		end else begin
			decode_mode = b ? bmsel_pkg::MODE_HOST : bmsel_pkg::MODE_NOBOOT;
		end
	endfunction

	// Ack only counts while the wait mode still demands it
	assign ackOk = ackIn || (unbankedWaitMode == bmsel_pkg::WAIT_MODE_INT);

	bmsel_fifo #(.WIDTH(bmsel_pkg::WORD_W), .DEPTH(bmsel_pkg::FIFO_DEPTH)) wordFifo (
		.mclk     (mclk),
		.resetn   (resetn),
		.inValid  (packValid),
		.inReady  (packReady),
		.inData   (packReg),
		.outValid (fifoValid),
		.outReady (1'b1),
		.outData  (fifoData)
	);

	// Straps are caught on the first clock after release, never inside the reset branch
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state              <= BMSEL_SAMPLE;
			bootMode           <= bmsel_pkg::MODE_NONE;
			bootChannelControl <= bmsel_pkg::BOOT_CTRL_RESET;
			bootInternalCount  <= bmsel_pkg::INT_COUNT_RESET;
			bootExternalCount  <= bmsel_pkg::EXT_COUNT_RESET;
			bootInternalStride <= bmsel_pkg::STRIDE_ONE;
			bootExternalStride <= bmsel_pkg::STRIDE_ONE;
			bootSpaceSelectBit <= 1'b0;
			extAddr            <= {8'h00, bmsel_pkg::EXT_INDEX_RESET};
			readStrobe         <= 1'b0;
			waitCnt            <= 4'h0;
			byteIdx            <= 3'h0;
			packReg            <= 48'h0;
			packValid          <= 1'b0;
			coreIdle           <= 1'b0;
			coreResume         <= 1'b0;
			programCounter     <= bmsel_pkg::RESET_VECTOR;
		end else begin
			coreResume <= 1'b0;
			case (state)
				BMSEL_SAMPLE: begin
					bootMode <= decode_mode(promBootStrap, linkBootStrap, bootSelectIn);
					coreIdle <= 1'b1;
					if (decode_mode(promBootStrap, linkBootStrap, bootSelectIn)
							== bmsel_pkg::MODE_PROM) begin
						bootSpaceSelectBit <= 1'b1;
						readStrobe         <= 1'b1;
						waitCnt            <= bmsel_pkg::PROM_WAIT_STATES;
						state              <= BMSEL_STROBE;
					end else if (decode_mode(promBootStrap, linkBootStrap, bootSelectIn)
							== bmsel_pkg::MODE_NOBOOT) begin
						coreIdle       <= 1'b0;
						programCounter <= bmsel_pkg::NOBOOT_VECTOR;
						state          <= BMSEL_HALT;
					end else begin
						state <= BMSEL_HALT;
					end
				end
				BMSEL_STROBE: begin
					// Six wait states plus the strobe cycle give seven cycles
					if (waitCnt != 4'h0) begin
						waitCnt <= waitCnt - 4'h1;
					end else if (ackOk) begin
						readStrobe <= 1'b0;
						packReg[8*byteIdx +: 8] <= extDataIn[bmsel_pkg::DATA_LSB +: 8];
						extAddr           <= extAddr + 32'h1;
						bootExternalCount <= bootExternalCount - 16'h1;
						state             <= BMSEL_PACK;
					end
				end
				BMSEL_PACK: begin
					if (byteIdx == bmsel_pkg::BYTES_PER_WORD - 3'h1) begin
						byteIdx           <= 3'h0;
						packValid         <= 1'b1;
						bootInternalCount <= bootInternalCount - 16'h1;
						state             <= BMSEL_DRAIN;
					end else begin
						byteIdx    <= byteIdx + 3'h1;
						readStrobe <= 1'b1;
						waitCnt    <= bmsel_pkg::PROM_WAIT_STATES;
						state      <= BMSEL_STROBE;
					end
				end
				BMSEL_DRAIN: begin
					// A full FIFO holds the word and so stalls the byte reads
					if (packReady) begin
						packValid <= 1'b0;
						if (bootInternalCount == 16'h0) begin
							state <= BMSEL_DONE;
						end else begin
							readStrobe <= 1'b1;
							waitCnt    <= bmsel_pkg::PROM_WAIT_STATES;
							state      <= BMSEL_STROBE;
						end
					end
				end
				BMSEL_DONE: begin
					if (!fifoValid) begin
						bootSpaceSelectBit <= 1'b0;
						coreIdle           <= 1'b0;
						coreResume         <= 1'b1;
						programCounter     <= bmsel_pkg::INT_INDEX_RESET;
						state              <= BMSEL_HALT;
					end
				end
				BMSEL_HALT: begin
					state <= BMSEL_HALT;
				end
				default: begin
					state <= BMSEL_HALT;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			unbankedWaitMode   <= bmsel_pkg::WAIT_MODE_BOTH;
			unbankedWaitStates <= bmsel_pkg::PROM_WAIT_STATES;
		end else if (waitModeWrite) begin
			unbankedWaitMode <= waitModeIn;
		end
	end

	// Internal memory writes come out of the FIFO at the incrementing index
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			internalIndex <= bmsel_pkg::INT_INDEX_RESET;
			memWrite      <= 1'b0;
			memAddr       <= 24'h0;
			memData       <= 48'h0;
		end else begin
			memWrite <= fifoValid;
			if (fifoValid) begin
				memAddr       <= internalIndex;
				memData       <= fifoData;
				internalIndex <= internalIndex + bootInternalStride;
			end
		end
	end

	// Chip select is active low and driven only by loader strobes, not core accesses
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			bootSelectOut   <= 1'b1;
			bootSelectOe    <= 1'b0;
			memSelectEnable <= 1'b1;
			ackOut          <= 1'b1;
			ackOe           <= 1'b1;
		end else begin
			ackOe           <= 1'b0;
			bootSelectOe    <= bootSpaceSelectBit;
			memSelectEnable <= !bootSpaceSelectBit;
			bootSelectOut   <= !(bootSpaceSelectBit && readStrobe) || coreExtAccess;
		end
	end

	logic [3:0] strobeLen;
	logic       stallCycle;
	// Stalled cycles are left out, so a held-off read still shows its wait states
	assign stallCycle = state == BMSEL_STROBE && waitCnt == 4'h0 && !ackOk;
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			strobeLen <= 4'h0;
		end else begin
			strobeLen <= readStrobe ? strobeLen + {3'h0, !stallCycle} : 4'h0;
		end
	end

	strobe_len_a: assert property (@(posedge mclk) disable iff (!resetn)
		$fell(readStrobe) |-> $past(strobeLen) == bmsel_pkg::PROM_WAIT_STATES)
		else $error("read strobe length wrong");
	count_start_a: assert property (@(posedge mclk) disable iff (!resetn)
		$rose(readStrobe) && $past(state) == BMSEL_SAMPLE |-> bootExternalCount == 16'h0600)
		else $error("external count not 0x600");
	addr_step_a: assert property (@(posedge mclk) disable iff (!resetn)
		$fell(readStrobe) |-> extAddr == $past(extAddr) + 32'h1)
		else $error("address did not step");
	sel_oe_a: assert property (@(posedge mclk) disable iff (!resetn)
		bootSelectOe |-> bootMode == bmsel_pkg::MODE_PROM)
		else $error("boot select driven outside prom boot");
	reserved_none_a: assert property (@(posedge mclk) disable iff (!resetn)
		bootMode == bmsel_pkg::MODE_RESERVED |-> !readStrobe && !bootSpaceSelectBit)
		else $error("reserved mode started a load");
	core_sel_a: assert property (@(posedge mclk) disable iff (!resetn)
		coreExtAccess |=> bootSelectOut)
		else $error("core access asserted boot select");
	sel_excl_a: assert property (@(posedge mclk) disable iff (!resetn)
		bootSelectOe |-> !memSelectEnable)
		else $error("normal selects enabled during boot");
	resume_pc_a: assert property (@(posedge mclk) disable iff (!resetn)
		coreResume |-> programCounter == 24'h040000 && bootInternalCount == 16'h0)
		else $error("resume before count done");
	ack_stall_a: assert property (@(posedge mclk) disable iff (!resetn)
		state == BMSEL_STROBE && waitCnt == 4'h0 && !ackOk |=> state == BMSEL_STROBE)
		else $error("low ack did not stall");
	word_cnt_a: assert property (@(posedge mclk) disable iff (!resetn)
		$rose(packValid) |-> byteIdx == 3'h0 &&
			bootExternalCount == 16'h6 * bootInternalCount)
		else $error("word packed at odd byte count");
	sel_dma_a: assert property (@(posedge mclk) disable iff (!resetn)
		!bootSelectOut |-> $past(readStrobe) && $past(bootSpaceSelectBit))
		else $error("boot select asserted without a loader strobe");
	ecount_step_a: assert property (@(posedge mclk) disable iff (!resetn)
		$fell(readStrobe) |-> bootExternalCount == $past(bootExternalCount) - 16'h1)
		else $error("external count did not step");
	wait_load_a: assert property (@(posedge mclk) disable iff (!resetn)
		$rose(readStrobe) |-> waitCnt == unbankedWaitStates)
		else $error("wait count not loaded from wait states");
	load_span_a: assert property (@(posedge mclk) disable iff (!resetn)
		coreResume |-> extAddr == {8'h00, bmsel_pkg::EXT_INDEX_RESET} + 32'h00000600)
		else $error("load did not cover all boot bytes");
	pc_idle_a: assert property (@(posedge mclk) disable iff (!resetn)
		bootSpaceSelectBit |-> coreIdle && programCounter == bmsel_pkg::RESET_VECTOR)
		else $error("core not idle at reset vector during load");
	noboot_pc_a: assert property (@(posedge mclk) disable iff (!resetn)
		bootMode == bmsel_pkg::MODE_NOBOOT |-> !coreIdle &&
			programCounter == bmsel_pkg::NOBOOT_VECTOR)
		else $error("no-boot did not start from external memory");
	host_quiet_a: assert property (@(posedge mclk) disable iff (!resetn)
		bootMode == bmsel_pkg::MODE_HOST |-> !bootSelectOe && !readStrobe && coreIdle)
		else $error("host boot started a loader read");
	sel_restore_a: assert property (@(posedge mclk) disable iff (!resetn)
		$fell(bootSpaceSelectBit) |=> memSelectEnable && !bootSelectOe && bootSelectOut)
		else $error("normal selects not restored after load");
	wait_write_a: assert property (@(posedge mclk) disable iff (!resetn)
		waitModeWrite |=> unbankedWaitMode == $past(waitModeIn))
		else $error("wait mode write not taken");

	prom_boot_c: cover property (@(posedge mclk) disable iff (!resetn) coreResume);
	noboot_c: cover property (@(posedge mclk) disable iff (!resetn)
		bootMode == bmsel_pkg::MODE_NOBOOT);
	stall_c: cover property (@(posedge mclk) disable iff (!resetn) packValid && !packReady);
	reserved_c: cover property (@(posedge mclk) disable iff (!resetn)
		bootMode == bmsel_pkg::MODE_RESERVED);
endmodule

// ===== bench/bmsel_prom_model.sv
// Behavioural byte-wide boot memory that answers on data lines 39..32
`timescale 1ns/1ns
module bmsel_prom_model (
	input  wire logic        chipSelectN,
	input  wire logic        readStrobe,
	input  wire logic [31:0] addr,
	output logic      [63:0] data
);
	function automatic logic [7:0] byteAt(input logic [31:0] a);
		return a[7:0] ^ a[15:8] ^ 8'hA5;
	endfunction
	// Deselected lines show the inverted pattern, so a stale sample never looks right
	always_comb begin
		if (!chipSelectN && readStrobe) begin
			data = {24'h000000, byteAt(addr), 32'h00000000};
		end else begin
			data = ~{24'h000000, byteAt(addr), 32'h00000000};
		end
	end
endmodule

// ===== bench/bmsel_loader_test.sv
// Self-checking bench for the boot mode decode and byte-wide boot loader
`timescale 1ns/1ns
module bmsel_loader_test;
	logic        mclk = 1'b0;
	logic        resetn = 1'b0;
	logic        pe = 1'b0;
	logic        pl = 1'b0;
	logic        bselDrv = 1'b1;
	logic        ackDrv = 1'b1;
	logic        core = 1'b0;
	logic        wmw = 1'b0;
	logic [1:0]  wm = 2'h0;
	logic        bsOut, bsOe, msEn, rdStb, ackOut, ackOe, memWrite, coreIdle, coreResume, boot_space_select_bit;
	logic [31:0] extAddr;
	logic [63:0] extData;
	logic [23:0] memAddr, pc, iStride, eStride;
	logic [47:0] memData;
	logic [2:0]  bootMode;
	logic [15:0] ctrl, iCount, eCount;
	logic [1:0]  waitMode;
	logic [3:0]  waitStates;
	wire         bootSel = bsOe ? bsOut : bselDrv;
	wire         ackLine = ackOe ? ackOut : ackDrv;
	int          fail_count = 0;
	int          num_checks = 0;
	int          wordsSeen = 0;
	int          bytesSeen = 0;
	int          width = 0;
	logic        prevStrobe = 1'b0;
	logic        prevCore = 1'b0;
	logic        skipWidth = 1'b0;

	bmsel_loader dut_u (.mclk(mclk), .resetn(resetn), .promBootStrap(pe), .linkBootStrap(pl),
		.bootSelectIn(bootSel), .bootSelectOut(bsOut), .bootSelectOe(bsOe),
		.memSelectEnable(msEn), .extAddr(extAddr), .extDataIn(extData), .readStrobe(rdStb),
		.ackIn(ackLine), .ackOut(ackOut), .ackOe(ackOe), .waitModeIn(wm), .waitModeWrite(wmw),
		.coreExtAccess(core), .memWrite(memWrite), .memAddr(memAddr), .memData(memData),
		.bootMode(bootMode), .coreIdle(coreIdle), .coreResume(coreResume), .programCounter(pc),
		.bootChannelControl(ctrl), .bootInternalCount(iCount), .bootExternalCount(eCount),
		.bootInternalStride(iStride), .bootExternalStride(eStride), .bootSpaceSelectBit(boot_space_select_bit),
		.unbankedWaitMode(waitMode), .unbankedWaitStates(waitStates));
	bmsel_prom_model prom_u (.chipSelectN(bootSel), .readStrobe(rdStb), .addr(extAddr),
		.data(extData));

	always #2 mclk = ~mclk;

	task automatic results();
		if (fail_count == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input logic [47:0] seen, input logic [47:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	function automatic logic [47:0] expWord(input int w);
		logic [47:0] r;
		logic [31:0] a;
		for (int i = 0; i < 6; i++) begin
			a = {8'h00, bmsel_pkg::EXT_INDEX_RESET} + 32'(6 * w + i);
			r[8*i +: 8] = a[7:0] ^ a[15:8] ^ 8'hA5;
		end
		return r;
	endfunction

	// Bus monitor on the falling edge, where registered outputs have settled
	always @(negedge mclk) begin
		if (prevCore) check(bsOut, 1'b1);
		if (memWrite === 1'b1) begin
			check(memAddr, bmsel_pkg::INT_INDEX_RESET + 24'(wordsSeen));
			check(memData, expWord(wordsSeen));
			check({bsOe, msEn, coreIdle, boot_space_select_bit}, 4'hB);
			check(pc, bmsel_pkg::RESET_VECTOR);
			wordsSeen++;
		end
		if (rdStb === 1'b1) begin
			width++;
		end else if (prevStrobe) begin
			bytesSeen++;
			if (!skipWidth) check(width, 7);
			skipWidth = 1'b0;
			width = 0;
			check(extAddr, {8'h00, bmsel_pkg::EXT_INDEX_RESET} + 32'(bytesSeen));
			check(eCount, bmsel_pkg::EXT_COUNT_RESET - 16'(bytesSeen));
		end
		prevStrobe = rdStb;
		prevCore = core;
	end

	task automatic doReset(input logic p, input logic l, input logic b);
		resetn = 1'b0;
		pe = p;
		pl = l;
		bselDrv = b;
		repeat (4) @(posedge mclk);
		#1;
		check({ackOe, ackOut}, 2'h3);
		resetn = 1'b1;
	endtask

	// Five of the six non-loading strap combinations (not all three high): decoded mode, pin direction, no transfers
	task automatic modeTest();
		logic [5:0] tbl [5] = '{6'h04, 6'h0A, 6'h15, 6'h1B, 6'h35};
		for (int k = 0; k < 5; k++) begin
			doReset(tbl[k][5], tbl[k][4], tbl[k][3]);
			repeat (10) @(posedge mclk);
			#1;
			check(bootMode, tbl[k][2:0]);
			check({bsOe, rdStb}, 2'h0);
			if (k == 0) check({pc, coreIdle}, {bmsel_pkg::NOBOOT_VECTOR, 1'b0});
		end
	endtask

	task automatic promTest();
		ackDrv = 1'b0;
		skipWidth = 1'b1;
		doReset(1'b1, 1'b0, 1'b1);
		repeat (2) @(posedge mclk);
		#1;
		check(bootMode, bmsel_pkg::MODE_PROM);
		check(ctrl, bmsel_pkg::BOOT_CTRL_RESET);
		check(iCount, bmsel_pkg::INT_COUNT_RESET);
		check(eCount, bmsel_pkg::EXT_COUNT_RESET);
		check({iStride, eStride}, {bmsel_pkg::STRIDE_ONE, bmsel_pkg::STRIDE_ONE});
		check(waitMode, bmsel_pkg::WAIT_MODE_BOTH);
		check(waitStates, bmsel_pkg::PROM_WAIT_STATES);
		repeat (20) @(posedge mclk);
		#1;
		check({rdStb, extAddr}, {1'b1, 8'h00, bmsel_pkg::EXT_INDEX_RESET});
		// Kernel switches to internal wait only while acknowledge stays low
		wm = bmsel_pkg::WAIT_MODE_INT;
		wmw = 1'b1;
		@(posedge mclk);
		#1;
		wmw = 1'b0;
		@(posedge mclk);
		#1;
		check(waitMode, bmsel_pkg::WAIT_MODE_INT);
		for (int n = 0; n < 20000 && (wordsSeen < 100 || rdStb !== 1'b0); n++) @(posedge mclk) #1;
		core = 1'b1; // Core access on the bus, never a second channel
		@(posedge mclk);
		#1;
		core = 1'b0;
		for (int n = 0; n < 20000 && coreResume !== 1'b1; n++) @(posedge mclk) #1;
		check(wordsSeen, 256);
		check(bytesSeen, 1536);
		check({iCount, eCount, boot_space_select_bit}, 33'h0);
		check(pc, bmsel_pkg::INT_INDEX_RESET);
		repeat (2) @(posedge mclk);
		#1;
		check({bsOe, msEn}, 2'h1);
		repeat (20) @(posedge mclk);
		#1;
		check({rdStb, bytesSeen}, {1'b0, 32'd1536});
	endtask

	initial begin
		modeTest();
		promTest();
		results();
	end

	// Full load takes about 13000 cycles; the limit at 30000 cycles means a hang
	initial begin
		#120000;
		fail_count++;
		results();
	end
endmodule
